// file: include/rlsub_pkg.sv
// Package with instruction encodings, field positions, reset values and carrier types.
package rlsub_pkg;
    localparam int INSTR_W = 12;
    localparam int DATA_W = 8;
    localparam int FILE_ADDR_W = 5;
    localparam int FILE_ADDR_LSB = 0;
    localparam int DEST_BIT = 5;
    localparam int LIT_LSB = 0;
    localparam int NIB_W = 4;
    localparam logic [INSTR_W-1:0] IDLE_INSTRUCTION_CODE = 12'h000;
    localparam logic [INSTR_W-1:0] OPTION_LOAD_CODE = 12'h002;
    localparam int RETLIT_OP_LSB = 8;
    localparam logic [3:0] RETURN_WITH_LITERAL_OP = 4'h8;
    localparam int SUBF_OP_LSB = 6;
    localparam logic [5:0] SUBTRACT_ACC_FROM_FILE_OP = 6'h02;
    localparam logic DEST_ACC = 1'b0;
    localparam logic DEST_FILE = 1'b1;
    localparam int RETURN_WITH_LITERAL_CYCLES = 2;
    localparam int PC_W_DEFAULT = 10;
    localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
    localparam logic [DATA_W-1:0] OPTION_RESET = 8'hff;

    typedef struct packed {
        logic carry;
        logic digit_carry;
        logic zero;
    } flags_t;

    typedef struct packed {
        logic we;
        logic [FILE_ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } file_wr_t;
endpackage

// file: rtl/sub_unit.sv
// Combinational two's complement subtractor giving file minus accumulator and its flags.
`timescale 1ns/1ps
module sub_unit (
    // Operands.
    input wire logic [rlsub_pkg::DATA_W-1:0] i_file_val,
    input wire logic [rlsub_pkg::DATA_W-1:0] i_acc_val,
    // Result.
    output logic [rlsub_pkg::DATA_W-1:0] o_diff,
    output rlsub_pkg::flags_t o_flags
);
    logic [rlsub_pkg::DATA_W:0] full;
    logic [rlsub_pkg::NIB_W:0] low;

    always_comb begin
        // The subtraction adds the inverted accumulator plus one, so carry means no borrow.
        full = {1'b0, i_file_val} + {1'b0, ~i_acc_val} + 9'h001;
        low = {1'b0, i_file_val[rlsub_pkg::NIB_W-1:0]} + {1'b0, ~i_acc_val[rlsub_pkg::NIB_W-1:0]} + 5'h01;
        o_diff = full[rlsub_pkg::DATA_W-1:0];
        o_flags.carry = full[rlsub_pkg::DATA_W];
        o_flags.digit_carry = low[rlsub_pkg::NIB_W];
        o_flags.zero = (full[rlsub_pkg::DATA_W-1:0] == 8'h00);
    end
endmodule

// file: rtl/return_literal_and_subtract_exec.sv
// Decode and execute unit for idle, option load, return with literal and subtract from file.
`timescale 1ns/1ps
module return_literal_and_subtract_exec #(
    parameter int PC_W = rlsub_pkg::PC_W_DEFAULT
) (
    // Clock, reset and enable.
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic i_ce,
    // Instruction issue.
    input wire logic i_instr_valid,
    input wire logic [rlsub_pkg::INSTR_W-1:0] i_instr,
    output logic o_ready,
    output logic o_done,
    output logic o_unhandled,
    // File register port and call stack.
    input wire logic [rlsub_pkg::DATA_W-1:0] i_file_rdata,
    input wire logic [PC_W-1:0] i_stack_top,
    output rlsub_pkg::file_wr_t o_file_wr,
    // Program counter load.
    output logic o_pc_load,
    output logic [PC_W-1:0] o_pc_value,
    output logic o_stack_pop,
    // Core registers and flags.
    output logic [rlsub_pkg::DATA_W-1:0] o_acc,
    output logic [rlsub_pkg::DATA_W-1:0] o_option,
    output rlsub_pkg::flags_t o_flags,
    output logic o_flags_we
);
    typedef enum logic [0:0] {ST_EXEC, ST_SECOND} state_t;

    logic rst_meta_r;
    logic rst_sync_r;
    state_t state_r, state_nxt;
    logic ready_r, ready_nxt;
    logic done_r, done_nxt;
    logic unhandled_r, unhandled_nxt;
    rlsub_pkg::file_wr_t file_wr_r, file_wr_nxt;
    logic pc_load_r, pc_load_nxt;
    logic [PC_W-1:0] pc_value_r, pc_value_nxt;
    logic stack_pop_r, stack_pop_nxt;
    logic [rlsub_pkg::DATA_W-1:0] acc_r, acc_nxt;
    logic [rlsub_pkg::DATA_W-1:0] option_r, option_nxt;
    rlsub_pkg::flags_t flags_r, flags_nxt;
    logic flags_we_r, flags_we_nxt;
    logic [rlsub_pkg::DATA_W-1:0] diff;
    rlsub_pkg::flags_t sub_flags;
    logic take;
    logic is_idle, is_option, is_retlit, is_subf;

    // Reset is asserted at once and released through two flip-flops.
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    sub_unit u_sub (
        .i_file_val(i_file_rdata),
        .i_acc_val(acc_r),
        .o_diff(diff),
        .o_flags(sub_flags)
    );

    always_comb begin
        take = i_instr_valid && ready_r && (state_r == ST_EXEC);
        is_idle = (i_instr == rlsub_pkg::IDLE_INSTRUCTION_CODE);
        is_option = (i_instr == rlsub_pkg::OPTION_LOAD_CODE);
        is_retlit = (i_instr[rlsub_pkg::INSTR_W-1:rlsub_pkg::RETLIT_OP_LSB] == rlsub_pkg::RETURN_WITH_LITERAL_OP);
        is_subf = (i_instr[rlsub_pkg::INSTR_W-1:rlsub_pkg::SUBF_OP_LSB] == rlsub_pkg::SUBTRACT_ACC_FROM_FILE_OP);
    end

    always_comb begin
        state_nxt = state_r;
        ready_nxt = ready_r;
        done_nxt = 1'b0;
        unhandled_nxt = 1'b0;
        file_wr_nxt = file_wr_r;
        file_wr_nxt.we = 1'b0;
        pc_load_nxt = 1'b0;
        pc_value_nxt = pc_value_r;
        stack_pop_nxt = 1'b0;
        acc_nxt = acc_r;
        option_nxt = option_r;
        flags_nxt = flags_r;
        flags_we_nxt = 1'b0;
        case (state_r)
            ST_EXEC: begin
                ready_nxt = 1'b1;
                if (take) begin
                    if (is_idle) begin
                        done_nxt = 1'b1;
                    end else if (is_option) begin
                        option_nxt = acc_r;
                        done_nxt = 1'b1;
                    end else if (is_retlit) begin
                        acc_nxt = i_instr[rlsub_pkg::LIT_LSB +: rlsub_pkg::DATA_W];
                        pc_value_nxt = i_stack_top;
                        pc_load_nxt = 1'b1;
                        stack_pop_nxt = 1'b1;
                        ready_nxt = 1'b0;
                        state_nxt = ST_SECOND;
                    end else if (is_subf) begin
                        flags_nxt = sub_flags;
                        flags_we_nxt = 1'b1;
                        done_nxt = 1'b1;
                        if (i_instr[rlsub_pkg::DEST_BIT] == rlsub_pkg::DEST_ACC) begin
                            acc_nxt = diff;
                        end else begin
                            file_wr_nxt.we = 1'b1;
                            file_wr_nxt.addr = i_instr[rlsub_pkg::FILE_ADDR_LSB +: rlsub_pkg::FILE_ADDR_W];
                            file_wr_nxt.data = diff;
                        end
                    end else begin
                        unhandled_nxt = 1'b1;
                    end
                end
            end
            ST_SECOND: begin
                // The fetched word after the return is discarded while the counter reloads.
                ready_nxt = 1'b1;
                done_nxt = 1'b1;
                state_nxt = ST_EXEC;
            end
            default: begin
                ready_nxt = 1'b0;
                state_nxt = ST_EXEC;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            state_r <= ST_EXEC;
            ready_r <= 1'b0;
            done_r <= 1'b0;
            unhandled_r <= 1'b0;
            file_wr_r <= '0;
            pc_load_r <= 1'b0;
            pc_value_r <= '0;
            stack_pop_r <= 1'b0;
            acc_r <= rlsub_pkg::ACC_RESET;
            option_r <= rlsub_pkg::OPTION_RESET;
            flags_r <= '0;
            flags_we_r <= 1'b0;
        end else if (i_ce) begin
            state_r <= state_nxt;
            ready_r <= ready_nxt;
            done_r <= done_nxt;
            unhandled_r <= unhandled_nxt;
            file_wr_r <= file_wr_nxt;
            pc_load_r <= pc_load_nxt;
            pc_value_r <= pc_value_nxt;
            stack_pop_r <= stack_pop_nxt;
            acc_r <= acc_nxt;
            option_r <= option_nxt;
            flags_r <= flags_nxt;
            flags_we_r <= flags_we_nxt;
        end
    end

    always_comb begin
        o_ready = ready_r;
        o_done = done_r;
        o_unhandled = unhandled_r;
        o_file_wr = file_wr_r;
        o_pc_load = pc_load_r;
        o_pc_value = pc_value_r;
        o_stack_pop = stack_pop_r;
        o_acc = acc_r;
        o_option = option_r;
        o_flags = flags_r;
        o_flags_we = flags_we_r;
    end
endmodule

// file: tb/rlsub_checker.sv
// Checker of the decode and execute unit's port behaviour.
`timescale 1ns/1ps
module rlsub_checker #(parameter int PC_W = 10) (
    input wire logic i_sys_clk, i_resetn, i_ce, i_instr_valid, o_ready, o_done, o_unhandled,
    input wire logic [11:0] i_instr,
    input wire logic [7:0] i_file_rdata, o_acc, o_option,
    input wire logic [PC_W-1:0] i_stack_top, o_pc_value,
    input wire rlsub_pkg::file_wr_t o_file_wr,
    input wire logic o_pc_load, o_stack_pop, o_flags_we,
    input wire rlsub_pkg::flags_t o_flags
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);
    wire logic take = i_ce && i_instr_valid && o_ready;
    wire logic is_ret = take && i_instr[11:8] == 4'h8;
    wire logic is_sub = take && i_instr[11:6] == 6'h02;
    wire logic [7:0] lit = i_instr[7:0];
    wire logic [4:0] fa = i_instr[4:0];
    wire logic [7:0] diff = i_file_rdata - o_acc;
    property p_ret_acc; is_ret |=> o_acc == $past(lit); endproperty
    a_ret_acc: assert property (p_ret_acc) else $error("literal missing");
    property p_ret_pc; is_ret |=> o_pc_load && o_stack_pop && o_pc_value == $past(i_stack_top); endproperty
    a_ret_pc: assert property (p_ret_pc) else $error("pc load wrong");
    property p_ret_two; is_ret |=> !o_done && !o_ready ##1 o_done && o_ready; endproperty
    a_ret_two: assert property (p_ret_two) else $error("return timing wrong");
    property p_sub_flags; is_sub |=> o_flags_we && o_flags.zero == ($past(diff) == 8'h00)
        && o_flags.carry == ($past(i_file_rdata) >= $past(o_acc))
        && o_flags.digit_carry == ($past(i_file_rdata[3:0]) >= $past(o_acc[3:0])); endproperty
    a_sub_flags: assert property (p_sub_flags) else $error("flags wrong");
    property p_sub_acc; is_sub && !i_instr[5] |=> o_acc == $past(diff) && !o_file_wr.we; endproperty
    a_sub_acc: assert property (p_sub_acc) else $error("acc result wrong");
    property p_sub_file; is_sub && i_instr[5] |=> o_file_wr.we && o_file_wr.data == $past(diff)
        && o_file_wr.addr == $past(fa) && $stable(o_acc); endproperty
    a_sub_file: assert property (p_sub_file) else $error("file result wrong");
    property p_option; take && i_instr == 12'h002 |=> o_option == $past(o_acc) && o_done && !o_flags_we; endproperty
    a_option: assert property (p_option) else $error("option wrong");
    property p_idle; take && i_instr == 12'h000 |=> o_done && $stable(o_acc) && !o_file_wr.we; endproperty
    a_idle: assert property (p_idle) else $error("idle wrong");
endmodule
bind return_literal_and_subtract_exec rlsub_checker #(.PC_W(PC_W)) u_chk (.i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn), .i_ce(i_ce), .i_instr_valid(i_instr_valid), .o_ready(o_ready), .o_done(o_done),
    .o_unhandled(o_unhandled), .i_instr(i_instr), .i_file_rdata(i_file_rdata), .o_acc(o_acc),
    .o_option(o_option), .i_stack_top(i_stack_top), .o_pc_value(o_pc_value), .o_file_wr(o_file_wr),
    .o_pc_load(o_pc_load), .o_stack_pop(o_stack_pop), .o_flags_we(o_flags_we), .o_flags(o_flags));

// file: tb/tb_return_literal_and_subtract_exec.sv
// Self-checking bench for the decode and execute unit.
`timescale 1ns/1ps
module tb_return_literal_and_subtract_exec;
    logic clk = 1'b0, rstn = 1'b0, ce = 1'b1, vld = 1'b0;
    logic [11:0] ins = 12'h000;
    logic [7:0] rd = 8'h00, acc_m, acc, opt;
    logic [9:0] st = 10'h000, pcv;
    logic rdy, done, unh, pcl, pop, fwe;
    rlsub_pkg::file_wr_t fw;
    rlsub_pkg::flags_t fl;
    int err_count = 0, total_checks = 0;
    always #2.5 clk = ~clk;
    return_literal_and_subtract_exec u_dut (.i_sys_clk(clk), .i_resetn(rstn), .i_ce(ce), .i_instr_valid(vld),
        .i_instr(ins), .o_ready(rdy), .o_done(done), .o_unhandled(unh), .i_file_rdata(rd), .i_stack_top(st),
        .o_file_wr(fw), .o_pc_load(pcl), .o_pc_value(pcv), .o_stack_pop(pop), .o_acc(acc), .o_option(opt),
        .o_flags(fl), .o_flags_we(fwe));
    task automatic wrap_up();
        if (err_count == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic issue(input logic [11:0] w, input logic [7:0] r, input logic [9:0] s);
        for (int i = 0; i < 20 && rdy !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        vld = 1'b1;
        ins = w;
        rd = r;
        st = s;
        @(posedge clk);
        #1;
        rd = ~r;
        st = ~s;
    endtask
    task automatic t_ret(input logic [7:0] k, input logic [9:0] s);
        issue({4'h8, k}, 8'h00, s);
        acc_m = k;
        chk(acc, k);
        chk({pcl, pop, pcv}, {2'b11, s});
        chk({rdy, done}, 2'b00);
        @(posedge clk);
        #1;
        chk({rdy, done}, 2'b11);
        chk({pcl, pop, pcv, acc}, {2'b00, s, k});
    endtask
    task automatic t_ce(input logic [7:0] k, input logic [9:0] s);
        ce = 1'b0;
        vld = 1'b1;
        ins = {4'h8, k};
        st = s;
        repeat (3) @(posedge clk);
        #1;
        chk({acc, pcl, pop}, {acc_m, 2'b00});
        ce = 1'b1;
        @(posedge clk);
        #1;
        acc_m = k;
        chk({acc, pcl, pcv, rdy}, {k, 1'b1, s, 1'b0});
        @(posedge clk);
        #1;
        chk({rdy, done, pcl}, 3'b110);
    endtask
    task automatic t_rst();
        rstn = 1'b0;
        #1;
        chk({acc, opt, rdy, done, pcl, fwe, fw.we}, {16'h00ff, 5'h00});
        repeat (2) @(posedge clk);
        #1;
        rstn = 1'b1;
        acc_m = 8'h00;
        @(posedge clk);
        #1;
        chk({rdy, acc}, {1'b0, 8'h00});
    endtask
    task automatic t_sub(input logic d, input logic [4:0] f, input logic [7:0] r);
        logic [7:0] df;
        df = r - acc_m;
        issue({6'h02, d, f}, r, 10'h000);
        chk({fl, fwe, done}, {r >= acc_m, r[3:0] >= acc_m[3:0], df == 8'h00, 2'b11});
        if (d)
            chk({fw.we, fw.addr, fw.data, acc}, {1'b1, f, df, acc_m});
        else begin
            chk({fw.we, acc}, {1'b0, df});
            acc_m = df;
        end
    endtask
    task automatic t_misc();
        issue(12'h000, 8'h00, 10'h000);
        chk({done, acc, fwe, fw.we}, {1'b1, acc_m, 2'b00});
        issue(12'h002, 8'h00, 10'h000);
        chk({done, opt, fwe}, {1'b1, acc_m, 1'b0});
        issue(12'h001, 8'h00, 10'h000);
        chk({unh, acc, fw.we}, {1'b1, acc_m, 1'b0});
    endtask
    initial begin
        acc_m = 8'h00;
        repeat (4) @(posedge clk);
        #1;
        chk({acc, opt}, 16'h00ff);
        rstn = 1'b1;
        t_misc();
        t_ret(8'ha5, 10'h3ff);
        t_misc();
        t_sub(1'b0, 5'h00, 8'h00);
        t_sub(1'b1, 5'h1f, 8'h5b);
        t_sub(1'b0, 5'h0a, 8'ha5);
        t_ce(8'h3c, 10'h2aa);
        t_ret(8'h0f, 10'h155);
        t_sub(1'b1, 5'h01, 8'h10);
        t_rst();
        t_misc();
        t_sub(1'b0, 5'h03, 8'h00);
        wrap_up();
    end
    initial begin
        #2000;
        err_count++;
        wrap_up();
    end
endmodule
